//--- bench/rre_file_model.sv
// behavioural data register file facing the rotate-right execute unit
`timescale 1ns/1ps
`default_nettype none
module rre_file_model (
   // clock
   input wire logic clk_sys,
   // access from the execute unit
   input wire logic [11:0] file_addr,
   input wire logic file_rd_en,
   input wire logic file_wr_en,
   input wire logic [7:0] file_wr_data,
   output logic [7:0] file_rd_data
);
   logic [7:0] mem [0:4095];

   initial file_rd_data = 8'hA5;

   // answer stands only in the quarter after the read request; elsewhere it toggles
   // every cycle so a late sample never picks up a stale byte by luck
   always @(posedge clk_sys) begin
      if (file_rd_en === 1'b1) begin
         file_rd_data <= mem[file_addr];
      end else begin
         file_rd_data <= ~file_rd_data;
      end
      if (file_wr_en === 1'b1) begin
         mem[file_addr] <= file_wr_data;
      end
   end
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench for the rotate-right execute unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct packed {logic [1:0] kind; logic [23:0] val;} rre_note_type;
   logic clk_sys, reset, reg_wr, reg_rd, instr_valid, instr_ready, instr_done;
   logic file_rd_en, file_wr_en, ext_s, c_s, z_s, n_s, bad_s, rd_pend, rd_seen, known_s;
   logic [3:0] reg_addr, bank_s;
   logic [15:0] reg_wdata, instr_word, reg_rdata;
   logic [11:0] file_addr, base_s, last_ad_s;
   logic [7:0] file_rd_data, file_wr_data, wreg_s, f;
   logic [7:0] shadow [0:4095];
   logic [5:0] ops [0:2];
   logic [31:0] r;
   rre_note_type notes[$];
   int error_cnt, check_count, seed, i, k;

   // free-running 100 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   rre_execute dut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .instr_word(instr_word), .instr_valid(instr_valid), .instr_ready(instr_ready),
      .instr_done(instr_done), .file_addr(file_addr), .file_rd_en(file_rd_en),
      .file_rd_data(file_rd_data), .file_wr_en(file_wr_en), .file_wr_data(file_wr_data));
   rre_file_model u_model (.clk_sys(clk_sys), .file_addr(file_addr),
      .file_rd_en(file_rd_en), .file_wr_en(file_wr_en), .file_wr_data(file_wr_data),
      .file_rd_data(file_rd_data));

   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic close_out;
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // bus cycles start and end on a rising edge; a gap edge avoids double assignment
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      notes.push_back({2'd2, 8'h00, e});
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
   endtask

   function automatic logic [15:0] st();
      return {8'h00, bad_s, 4'h0, n_s, z_s, c_s};
   endfunction

   // works out the expected outcome, then offers the word until a quarter-one edge takes it
   task automatic exec(input logic [5:0] opc, input logic d, input logic a,
                       input logic [7:0] fa, input logic hold);
      logic [7:0] v;
      logic [7:0] res;
      known_s = (opc == rre_pkg::OPC_ROT_NOCARRY) || (opc == rre_pkg::OPC_ROT_THRU);
      if (a) last_ad_s = {bank_s, fa};
      else if (ext_s && fa <= rre_pkg::ACCESS_LIMIT) last_ad_s = base_s + {4'h0, fa};
      else if (fa > rre_pkg::ACCESS_LIMIT) last_ad_s = {rre_pkg::SFR_BANK, fa};
      else last_ad_s = {rre_pkg::LOW_BANK, fa};
      v = shadow[last_ad_s];
      res = (opc == rre_pkg::OPC_ROT_THRU) ? {c_s, v[7:1]} : {v[0], v[7:1]};
      if (!known_s) begin
         bad_s = 1'b1;
      end else begin
         if (opc == rre_pkg::OPC_ROT_THRU) c_s = v[0];
         n_s = res[7];
         z_s = (res == 8'h00);
         if (d) shadow[last_ad_s] = res;
         else wreg_s = res;
      end
      notes.push_back({known_s ? 2'd0 : 2'd1, 2'b00, known_s, known_s & d,
                       (known_s & d) ? res : 8'h00, last_ad_s});
      instr_word <= {opc, d, a, fa};
      instr_valid <= 1'b1;
      do @(negedge clk_sys); while (instr_ready !== 1'b1);
      @(posedge clk_sys);
      if (!hold) begin
         instr_valid <= 1'b0;
         repeat (2) @(posedge clk_sys);
         #1 chk("instr_done", 24'h1, {23'h0, instr_done});
         @(posedge clk_sys);
      end
   endtask

   // result watcher: takes the oldest note whenever a read answer or a completion shows
   always @(posedge clk_sys) begin
      rre_note_type nt;
      logic [23:0] obs;
      if (file_rd_en === 1'b1) rd_seen = 1'b1;
      if (rd_pend === 1'b1 || instr_done === 1'b1) begin
         if (notes.size() == 0) begin
            chk("note queue", 24'h0, 24'h1);
         end else begin
            nt = notes.pop_front();
            obs = {2'b00, rd_seen, file_wr_en, (file_wr_en === 1'b1) ? file_wr_data : 8'h00,
                   file_addr};
            if (nt.kind == 2'd2) chk("reg_rdata", nt.val, {8'h00, reg_rdata});
            else if (nt.kind == 2'd1) chk("bad op", nt.val & 24'hF00000, obs & 24'hF00000);
            else chk("file access", nt.val, obs);
            if (instr_done === 1'b1) rd_seen = 1'b0;
         end
      end
      rd_pend = reg_rd;
   end

   // watchdog sized well above the whole run
   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      close_out();
   end

   initial begin
      seed = 32'h83dc;
      {reg_wr, reg_rd, instr_valid, reg_addr, reg_wdata, instr_word} = '0;
      {ext_s, c_s, z_s, n_s, bad_s, rd_pend, rd_seen, bank_s, base_s, wreg_s} = '0;
      reset = 1'b1;
      ops[0] = rre_pkg::OPC_ROT_NOCARRY;
      ops[1] = rre_pkg::OPC_ROT_THRU;
      ops[2] = 6'h3F;
      for (i = 0; i < 4096; i++) begin
         r = $random(seed);
         shadow[i] = r[7:0];
         u_model.mem[i] = r[7:0];
      end
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      // reset values and an unmapped place
      for (i = 0; i < 5; i++) rd(i[3:0], 16'h0000);
      rd(4'hA, 16'h0000);
      for (i = 0; i < 48; i++) begin
         if (i % 6 == 0) begin
            r = $random(seed);
            {wreg_s, base_s, bank_s, ext_s} = r[24:0];
            {c_s, z_s, n_s, bad_s} = '0;
            wr(rre_pkg::OFS_CTRL, {15'h0, ext_s});
            wr(rre_pkg::OFS_BANK_SEL, {12'h0, bank_s});
            wr(rre_pkg::OFS_INDEX_BASE, {4'h0, base_s});
            wr(rre_pkg::OFS_WREG, {8'h00, wreg_s});
            wr(rre_pkg::OFS_STATUS, 16'h0080);
            wr(4'hA, 16'hFFFF);
            rd(rre_pkg::OFS_BANK_SEL, {12'h0, bank_s});
            rd(rre_pkg::OFS_INDEX_BASE, {4'h0, base_s});
            rd(rre_pkg::OFS_CTRL, {15'h0, ext_s});
         end
         r = $random(seed);
         k = (r[1:0] == 2'd3) ? 0 : int'(r[1:0]);
         f = (i % 4 == 1) ? 8'h5F : (i % 4 == 2) ? 8'h60 : r[11:4];
         exec(ops[k], r[2], r[3], f, 1'b0);
         rd(rre_pkg::OFS_WREG, {8'h00, wreg_s});
         rd(rre_pkg::OFS_STATUS, st());
         if (known_s) begin
            wr(rre_pkg::OFS_LAST_ADDR, {4'h0, ~last_ad_s});
            rd(rre_pkg::OFS_LAST_ADDR, {4'h0, last_ad_s});
         end
      end
      // back-to-back instruction cycles, valid held high between them
      for (i = 0; i < 8; i++) begin
         r = $random(seed);
         k = (r[1:0] == 2'd3) ? 1 : int'(r[1:0]);
         exec(ops[k], r[2], r[3], r[11:4], i < 7);
      end
      rd(rre_pkg::OFS_WREG, {8'h00, wreg_s});
      rd(rre_pkg::OFS_STATUS, st());
      repeat (3) @(posedge clk_sys);
      chk("notes left", 24'h0, 24'(notes.size()));
      close_out();
   end
endmodule
`default_nettype wire

//--- pkg/rre_alu_if.sv
// carrier between the execute sequencer and the rotate datapath
`timescale 1ns/1ps
`default_nettype none
interface rre_alu_if;
   logic [7:0] operand;
   logic carry_in;
   logic through_carry;
   logic [7:0] result;
   logic carry_out;
   logic neg;
   logic zero;

   // sequencer drives operand and mode, datapath answers
   modport core (output operand, output carry_in, output through_carry,
                 input result, input carry_out, input neg, input zero);
   modport alu (input operand, input carry_in, input through_carry,
                output result, output carry_out, output neg, output zero);
endinterface
`default_nettype wire

//--- pkg/rre_pkg.sv
// constants and types shared by the rotate-right execute unit
package rre_pkg;

   // register port offsets (word index on the plain register port)
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_BANK_SEL = 4'h1;
   localparam logic [3:0] OFS_INDEX_BASE = 4'h2;
   localparam logic [3:0] OFS_WREG = 4'h3;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_LAST_ADDR = 4'h5;

   // control register fields
   localparam int CTRL_EXT_BIT = 0;

   // status register fields
   localparam int ST_CARRY_BIT = 0;
   localparam int ST_ZERO_BIT = 1;
   localparam int ST_NEG_BIT = 2;
   localparam int ST_BADOP_BIT = 7;

   // reset values
   localparam logic CTRL_EXT_RST = 1'b0;
   localparam logic [3:0] BANK_SEL_RST = 4'h0;
   localparam logic [11:0] INDEX_BASE_RST = 12'h000;
   localparam logic [7:0] WREG_RST = 8'h00;

   // instruction word fields
   localparam int OPC_MSB = 15;
   localparam int OPC_LSB = 10;
   localparam int DEST_BIT = 9;
   localparam int ACCESS_BIT = 8;
   localparam logic [5:0] OPC_ROT_NOCARRY = 6'h10;
   localparam logic [5:0] OPC_ROT_THRU = 6'h0C;

   // access bank split and bank numbers
   localparam logic [7:0] ACCESS_LIMIT = 8'h5F;
   localparam logic [3:0] LOW_BANK = 4'h0;
   localparam logic [3:0] SFR_BANK = 4'hF;

   // one instruction cycle is four clocks, one per quarter
   typedef enum logic [1:0] {
      PH_Q1 = 2'b00,
      PH_Q2 = 2'b01,
      PH_Q3 = 2'b10,
      PH_Q4 = 2'b11
   } rre_phase_type;

   // instruction kind held while it is in flight
   typedef enum logic [1:0] {
      OP_NONE = 2'b00,
      OP_NOCARRY = 2'b01,
      OP_THRU = 2'b10
   } rre_op_type;

endpackage

//--- src/rre_execute.sv
// rotate-right execute unit: quarter sequencer, operand addressing, registers
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - With the access flag clear the operand sits in the access bank unless indexed, and the bank select is ignored; with it set that register picks the bank.
// - With the access flag clear, the extended set on and a file operand of 95 or less, the operand address is the index base plus the operand.
// - The no-carry rotate (opcode 010000) moves every bit right one place, copies bit 0 into bit 7 and updates only the sign and zero flags.
// - A destination bit of 0 sends the result to the working accumulator, a 1 writes it back to the source file register.
// - The through-carry rotate (opcode 001100) moves old bit 0 into carry and old carry into bit 7, updating carry, sign and zero.
module rre_execute (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // instruction from the decoder
   input wire logic [15:0] instr_word,
   input wire logic instr_valid,
   output logic instr_ready,
   output logic instr_done,
   // data register file
   output logic [11:0] file_addr,
   output logic file_rd_en,
   input wire logic [7:0] file_rd_data,
   output logic file_wr_en,
   output logic [7:0] file_wr_data
);

   // quarter sequencer state
   rre_pkg::rre_phase_type phase_r;
   rre_pkg::rre_phase_type phase_nxt;

   // software-visible state
   logic ext_en_r;
   logic [3:0] bank_sel_r;
   logic [11:0] index_base_r;
   logic [7:0] wreg_r;
   logic carry_r;
   logic zero_r;
   logic neg_r;
   logic bad_op_r;
   logic [15:0] reg_rdata_r;

   // instruction in flight
   rre_pkg::rre_op_type op_r;
   logic dest_r;
   logic busy_r;
   logic [11:0] file_addr_r;
   logic rd_en_r;
   logic wr_en_r;
   logic done_r;
   logic [7:0] operand_r;
   logic [7:0] result_r;
   logic res_carry_r;
   logic res_zero_r;
   logic res_neg_r;

   // decode of the word offered in the first quarter
   wire logic accept;
   wire logic [5:0] in_opc;
   wire logic [7:0] in_f;
   wire logic in_access;
   wire logic is_nocarry;
   wire logic is_thru;
   wire logic use_indexed;
   wire logic [11:0] access_addr;
   wire logic [11:0] indexed_addr;
   wire logic [11:0] banked_addr;
   wire logic [11:0] resolved_addr;
   wire rre_pkg::rre_op_type in_op;

   // register port decode
   wire logic wr_ctrl;
   wire logic wr_bank;
   wire logic wr_index;
   wire logic wr_wreg;
   wire logic wr_status;
   wire logic [15:0] rd_mux;

   // commit point at the end of the fourth quarter
   wire logic commit;
   wire logic commit_w;
   wire logic commit_flags;

   rre_alu_if alu_bus ();

   rre_rotate_unit u_rotate (
      .alu_port(alu_bus.alu)
   );

   // decoder is only heard in the first quarter, so one word per cycle
   assign instr_ready = (phase_r == rre_pkg::PH_Q1);
   assign accept = instr_ready & instr_valid;
   assign in_opc = instr_word[rre_pkg::OPC_MSB:rre_pkg::OPC_LSB];
   assign in_f = instr_word[7:0];
   assign in_access = ~instr_word[rre_pkg::ACCESS_BIT];
   assign is_nocarry = (in_opc == rre_pkg::OPC_ROT_NOCARRY);
   assign is_thru = (in_opc == rre_pkg::OPC_ROT_THRU);
   assign in_op = is_nocarry ? rre_pkg::OP_NOCARRY :
                  is_thru ? rre_pkg::OP_THRU : rre_pkg::OP_NONE;

   // operand address: access bank, indexed literal offset or banked
   assign access_addr = (in_f > rre_pkg::ACCESS_LIMIT) ? {rre_pkg::SFR_BANK, in_f}
                                                       : {rre_pkg::LOW_BANK, in_f};
   assign use_indexed = in_access & ext_en_r & (in_f <= rre_pkg::ACCESS_LIMIT);
   assign indexed_addr = index_base_r + {4'h0, in_f}; // wraps inside the 4K space
   assign banked_addr = {bank_sel_r, in_f};
   assign resolved_addr = !in_access ? banked_addr :
                          use_indexed ? indexed_addr : access_addr;

   // datapath sees the byte the register file returns in the third quarter
   assign alu_bus.operand = file_rd_data;
   assign alu_bus.carry_in = carry_r;
   assign alu_bus.through_carry = (op_r == rre_pkg::OP_THRU);

   // results land on the fourth-quarter edge
   assign commit = (phase_r == rre_pkg::PH_Q4) & done_r;
   assign commit_flags = commit & (op_r != rre_pkg::OP_NONE);
   assign commit_w = commit_flags & ~dest_r;

   // register port decode; hardware updates win over these writes
   assign wr_ctrl = reg_wr & (reg_addr == rre_pkg::OFS_CTRL);
   assign wr_bank = reg_wr & (reg_addr == rre_pkg::OFS_BANK_SEL);
   assign wr_index = reg_wr & (reg_addr == rre_pkg::OFS_INDEX_BASE);
   assign wr_wreg = reg_wr & (reg_addr == rre_pkg::OFS_WREG);
   assign wr_status = reg_wr & (reg_addr == rre_pkg::OFS_STATUS);
   assign rd_mux = (reg_addr == rre_pkg::OFS_CTRL) ? {15'h0000, ext_en_r} :
                   (reg_addr == rre_pkg::OFS_BANK_SEL) ? {12'h000, bank_sel_r} :
                   (reg_addr == rre_pkg::OFS_INDEX_BASE) ? {4'h0, index_base_r} :
                   (reg_addr == rre_pkg::OFS_WREG) ? {8'h00, wreg_r} :
                   (reg_addr == rre_pkg::OFS_STATUS) ?
                      {8'h00, bad_op_r, 4'h0, neg_r, zero_r, carry_r} :
                   (reg_addr == rre_pkg::OFS_LAST_ADDR) ? {4'h0, file_addr_r} :
                   16'h0000; // unmapped reads as zero

   // outputs
   assign reg_rdata = reg_rdata_r;
   assign instr_done = done_r;
   assign file_addr = file_addr_r;
   assign file_rd_en = rd_en_r;
   assign file_wr_en = wr_en_r;
   assign file_wr_data = result_r;

   // quarters advance every clock, one instruction cycle per four clocks
   always_comb begin
      case (phase_r)
         rre_pkg::PH_Q1: phase_nxt = rre_pkg::PH_Q2;
         rre_pkg::PH_Q2: phase_nxt = rre_pkg::PH_Q3;
         rre_pkg::PH_Q3: phase_nxt = rre_pkg::PH_Q4;
         rre_pkg::PH_Q4: phase_nxt = rre_pkg::PH_Q1;
         default: phase_nxt = rre_pkg::PH_Q1;
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         phase_r <= rre_pkg::PH_Q1;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   // first quarter: decode and present the operand address for the read
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         op_r <= rre_pkg::OP_NONE;
         dest_r <= 1'b0;
         busy_r <= 1'b0;
         file_addr_r <= 12'h000;
         rd_en_r <= 1'b0;
      end else begin
         rd_en_r <= accept & (in_op != rre_pkg::OP_NONE);
         if (accept) begin
            op_r <= in_op;
            dest_r <= instr_word[rre_pkg::DEST_BIT];
            busy_r <= 1'b1;
            file_addr_r <= resolved_addr;
         end else if (commit) begin
            busy_r <= 1'b0;
         end
      end
   end

   // third quarter: the read data is back, rotate it and hold the outcome
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         operand_r <= 8'h00;
         result_r <= 8'h00;
         res_carry_r <= 1'b0;
         res_zero_r <= 1'b0;
         res_neg_r <= 1'b0;
         wr_en_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         wr_en_r <= 1'b0;
         done_r <= 1'b0;
         if ((phase_r == rre_pkg::PH_Q3) && busy_r) begin
            operand_r <= file_rd_data;
            result_r <= alu_bus.result;
            res_carry_r <= alu_bus.carry_out;
            res_zero_r <= alu_bus.zero;
            res_neg_r <= alu_bus.neg;
            wr_en_r <= dest_r & (op_r != rre_pkg::OP_NONE);
            done_r <= 1'b1;
         end
      end
   end

   // software settings; no hardware source competes for these
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ext_en_r <= rre_pkg::CTRL_EXT_RST;
         bank_sel_r <= rre_pkg::BANK_SEL_RST;
         index_base_r <= rre_pkg::INDEX_BASE_RST;
      end else begin
         if (wr_ctrl) ext_en_r <= reg_wdata[rre_pkg::CTRL_EXT_BIT];
         if (wr_bank) bank_sel_r <= reg_wdata[3:0];
         if (wr_index) index_base_r <= reg_wdata[11:0];
      end
   end

   // accumulator and flags: the instruction result wins over a software write
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wreg_r <= rre_pkg::WREG_RST;
         carry_r <= 1'b0;
         zero_r <= 1'b0;
         neg_r <= 1'b0;
         bad_op_r <= 1'b0;
      end else begin
         if (commit_w) wreg_r <= result_r;
         else if (wr_wreg) wreg_r <= reg_wdata[7:0];
         if (commit_flags) begin
            if (op_r == rre_pkg::OP_THRU) carry_r <= res_carry_r;
            zero_r <= res_zero_r;
            neg_r <= res_neg_r;
         end else if (wr_status) begin
            carry_r <= reg_wdata[rre_pkg::ST_CARRY_BIT];
            zero_r <= reg_wdata[rre_pkg::ST_ZERO_BIT];
            neg_r <= reg_wdata[rre_pkg::ST_NEG_BIT];
         end
         // unknown opcode is sticky, write 1 clears, a new one wins
         if (commit && (op_r == rre_pkg::OP_NONE)) bad_op_r <= 1'b1;
         else if (wr_status && reg_wdata[rre_pkg::ST_BADOP_BIT]) bad_op_r <= 1'b0;
      end
   end

   // read data stands in the cycle after the strobe only
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         reg_rdata_r <= 16'h0000;
      end else begin
         reg_rdata_r <= reg_rd ? rd_mux : 16'h0000;
      end
   end

   // banked operand follows the bank select register
   bank_select_a: assert property (@(posedge clk_sys) disable iff (reset)
      accept && instr_word[rre_pkg::ACCESS_BIT]
      |=> file_addr == {$past(bank_sel_r), $past(instr_word[7:0])})
      else $error("banked address does not follow bank select");

   // access bank ignores bank select unless indexing applies
   access_bank_a: assert property (@(posedge clk_sys) disable iff (reset)
      accept && !instr_word[rre_pkg::ACCESS_BIT]
      && (!ext_en_r || instr_word[7:0] > rre_pkg::ACCESS_LIMIT)
      |=> file_addr == (($past(instr_word[7:0]) > rre_pkg::ACCESS_LIMIT)
                        ? {rre_pkg::SFR_BANK, $past(instr_word[7:0])}
                        : {rre_pkg::LOW_BANK, $past(instr_word[7:0])}))
      else $error("access bank address wrong");

   // indexed literal offset adds the operand to the index base
   indexed_offset_a: assert property (@(posedge clk_sys) disable iff (reset)
      accept && !instr_word[rre_pkg::ACCESS_BIT] && ext_en_r
      && instr_word[7:0] <= rre_pkg::ACCESS_LIMIT
      |=> file_addr == 12'($past(index_base_r) + {4'h0, $past(instr_word[7:0])}))
      else $error("indexed address wrong");

   // no-carry rotate copies bit 0 to the top and keeps carry
   nocarry_rotate_a: assert property (@(posedge clk_sys) disable iff (reset)
      commit && op_r == rre_pkg::OP_NOCARRY
      |-> result_r == {operand_r[0], operand_r[7:1]}
          ##1 carry_r == $past(carry_r) && zero_r == ($past(result_r) == 8'h00))
      else $error("no-carry rotate wrong");

   // destination bit steers the result
   dest_select_a: assert property (@(posedge clk_sys) disable iff (reset)
      commit_flags
      |-> (file_wr_en == dest_r) ##1 (!$past(dest_r) -> wreg_r == $past(result_r)))
      else $error("destination select wrong");

   // through-carry rotate swaps bit 0 and carry
   thru_carry_a: assert property (@(posedge clk_sys) disable iff (reset)
      commit && op_r == rre_pkg::OP_THRU
      |-> result_r[7] == $past(carry_r) && result_r[6:0] == operand_r[7:1]
          ##1 carry_r == $past(operand_r[0]) && neg_r == $past(result_r[7]))
      else $error("through-carry rotate wrong");

   // read in the second quarter, done in the fourth, then ready again in the next first quarter
   quarter_order_a: assert property (@(posedge clk_sys) disable iff (reset)
      accept && in_op != rre_pkg::OP_NONE
      |=> file_rd_en && !instr_done ##1 !file_rd_en ##1 instr_done ##1 !instr_done && instr_ready)
      else $error("quarter sequence broken");

endmodule
`default_nettype wire

//--- src/rre_rotate_unit.sv
// combinational rotate-right datapath with flag outputs
`timescale 1ns/1ps
`default_nettype none
module rre_rotate_unit (
   // operand in, rotated byte and flags out
   rre_alu_if.alu alu_port
);
   // both flavours shift right; only the bit entering the top differs
   function automatic logic [7:0] rot_right(input logic [7:0] v, input logic top);
      rot_right = {top, v[7:1]};
   endfunction

   wire logic top_bit;
   wire logic [7:0] rotated;

   // no-carry copies bit 0 round, through-carry brings in the old carry
   assign top_bit = alu_port.through_carry ? alu_port.carry_in : alu_port.operand[0];
   assign rotated = rot_right(alu_port.operand, top_bit);

   // flags follow the rotated byte; the no-carry form leaves carry alone
   assign alu_port.result = rotated;
   assign alu_port.carry_out = alu_port.through_carry ? alu_port.operand[0]
                                                      : alu_port.carry_in;
   assign alu_port.neg = rotated[7];
   assign alu_port.zero = (rotated == 8'h00);
endmodule
`default_nettype wire
